// file: design/xmap_window_mapper.sv
// address decoder and bank pager between the mcu core and its buses
// assumes the core presents one request per cycle on the same clock
`timescale 1ns/100ps

module xmap_window_mapper (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // core side
  input wire xmap_pkg::core_req_t core_req,
  output logic [7:0] bank_rdata_q,
  output logic bank_hit_q,
  // translated request
  output xmap_pkg::xlat_t xlat_q,
  output xmap_pkg::target_t target_q,
  // bank state, visible for debug
  output logic [7:0] flash_window_primary_bank_q,
  output logic [7:0] flash_window_secondary_bank_q,
  output logic [7:0] isa_io_window_bank_q,
  output logic [7:0] isa_memory_window_bank_q
);
  import xmap_pkg::*;

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  logic [15:0] a;
  logic [1:0] quad;
  logic xdata_acc;
  logic code_acc;
  logic bank_sel;
  logic [7:0] bank_rd_d;
  target_t target_d;
  logic [5:0] flash_bank;
  logic [19:0] flash_d;

  assign a = core_req.addr;
  assign quad = a[15:14];
  assign xdata_acc = core_req.valid && (core_req.kind == acc_xdata);
  assign code_acc = core_req.valid && (core_req.kind == acc_code);

  always_comb begin
    bank_sel = 1'b1;
    bank_rd_d = 8'h00;
    case (a)
      off_flash_secondary: bank_rd_d = flash_window_secondary_bank_q;
      off_flash_primary: bank_rd_d = flash_window_primary_bank_q;
      off_isa_io: bank_rd_d = isa_io_window_bank_q;
      off_isa_mem: bank_rd_d = isa_memory_window_bank_q;
      default: bank_sel = 1'b0;
    endcase
  end

  // bank choice per quadrant; both spaces share the upper half
  always_comb begin
    case (quad)
      quad_fixed: flash_bank = 6'h00;
      quad_low: flash_bank = flash_window_primary_bank_q[5:0];
      quad_sec: flash_bank = flash_window_secondary_bank_q[5:0];
      quad_alias: flash_bank = flash_window_primary_bank_q[5:0];
      default: flash_bank = 6'h00;
    endcase
  end
  assign flash_d = {flash_bank, a[13:0]};

  always_comb begin
    target_d = tgt_none;
    if (core_req.valid) begin
      case (core_req.kind)
        acc_direct: begin
          if (a[7:0] >= iram_upper_base) begin
            target_d = tgt_special_function_space;
          end else begin
            target_d = tgt_iram;
          end
        end
        acc_indirect: target_d = tgt_iram;
        acc_code: target_d = tgt_flash;
        acc_xdata: begin
          if (quad[1]) begin
            target_d = tgt_flash;
          end else if (a >= isa_io_lo && a <= isa_io_hi) begin
            target_d = tgt_isa_io;
          end else if (a >= isa_mem_lo && a <= isa_mem_hi) begin
            target_d = tgt_isa_mem;
          end else if (a >= periph_lo && a <= periph_hi) begin
            target_d = tgt_periph;
          end else begin
            target_d = tgt_onchip;
          end
        end
        default: target_d = tgt_none;
      endcase
    end
  end

  // ---------------------------------------------
  // bank registers
  // ---------------------------------------------
  // a write relocates the window from the next access on
  always_ff @(posedge mclk) begin
    if (reset) begin
      flash_window_secondary_bank_q <= rst_flash_secondary;
      flash_window_primary_bank_q <= rst_flash_primary;
      isa_io_window_bank_q <= rst_isa_io;
      isa_memory_window_bank_q <= rst_isa_mem;
    end else if (xdata_acc && core_req.write) begin
      case (a)
        off_flash_secondary: flash_window_secondary_bank_q <= core_req.wdata;
        off_flash_primary: flash_window_primary_bank_q <= core_req.wdata;
        off_isa_io: isa_io_window_bank_q <= core_req.wdata;
        off_isa_mem: isa_memory_window_bank_q <= core_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bank_hit_q <= 1'b0;
      bank_rdata_q <= 8'h00;
    end else begin
      bank_hit_q <= xdata_acc && bank_sel;
      bank_rdata_q <= (xdata_acc && bank_sel && !core_req.write) ? bank_rd_d : 8'h00;
    end
  end

  // ---------------------------------------------
  // translation outputs
  // ---------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      xlat_q <= '0;
      target_q <= tgt_none;
    end else begin
      target_q <= target_d;
      xlat_q.valid <= core_req.valid;
      // code space is read-only
      xlat_q.write <= core_req.write && !code_acc;
      xlat_q.iram_addr <= a[7:0];
      xlat_q.bit_area <= (a[7:0] >= bit_area_base) && (a[7:0] <= bit_area_last);
      xlat_q.isa_io_addr <= {isa_io_window_bank_q, a[7:0]};
      // isa memory: 8-bit bank above a 12-bit offset spans 1 MB
      xlat_q.isa_mem_addr <= {isa_memory_window_bank_q, a[11:0]};
      xlat_q.flash_addr <= flash_d;
      xlat_q.local_addr <= a;
      xlat_q.wdata <= core_req.wdata;
    end
  end

endmodule

// file: inc/xmap_pkg.sv
// address map constants and carrier types for the code/xdata window mapper
// assumes one mcu clock domain; all widths fixed
package xmap_pkg;

  // internal ram and special function space
  localparam int iram_bytes = 256;
  localparam logic [7:0] iram_upper_base = 8'h80;
  localparam logic [7:0] bit_area_base = 8'h20;
  localparam logic [7:0] bit_area_last = 8'h2f;

  // bank register offsets in xdata space
  localparam logic [15:0] off_flash_secondary = 16'h7f28;
  localparam logic [15:0] off_flash_primary = 16'h7f29;
  localparam logic [15:0] off_isa_io = 16'h7f71;
  localparam logic [15:0] off_isa_mem = 16'h7f72;

  // bank register reset values
  localparam logic [7:0] rst_flash_secondary = 8'h00;
  localparam logic [7:0] rst_flash_primary = 8'h00;
  localparam logic [7:0] rst_isa_io = 8'h00;
  localparam logic [7:0] rst_isa_mem = 8'h00;

  // xdata window bounds
  localparam logic [15:0] isa_io_lo = 16'h4000;
  localparam logic [15:0] isa_io_hi = 16'h40ff;
  localparam logic [15:0] isa_mem_lo = 16'h5000;
  localparam logic [15:0] isa_mem_hi = 16'h5fff;
  localparam logic [15:0] periph_lo = 16'h4000;
  localparam logic [15:0] periph_hi = 16'h7fff;

  // 16 KB quadrant selects, core address bits 15:14
  localparam logic [1:0] quad_fixed = 2'b00;
  localparam logic [1:0] quad_low = 2'b01;
  localparam logic [1:0] quad_sec = 2'b10;
  localparam logic [1:0] quad_alias = 2'b11;

  // decoded target of an access
  typedef enum {
    tgt_none,
    tgt_iram,
    tgt_special_function_space,
    tgt_onchip,
    tgt_periph,
    tgt_isa_io,
    tgt_isa_mem,
    tgt_flash
  } target_t;

  // access kinds issued by the core
  typedef enum logic [1:0] {
    acc_direct = 2'b00,
    acc_indirect = 2'b01,
    acc_xdata = 2'b10,
    acc_code = 2'b11
  } access_t;

  // request from the core
  typedef struct packed {
    logic valid;
    logic write;
    access_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } core_req_t;

  // decoded and translated request
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] iram_addr;
    logic bit_area;
    logic [15:0] isa_io_addr;
    logic [19:0] isa_mem_addr;
    logic [19:0] flash_addr;
    logic [15:0] local_addr;
    logic [7:0] wdata;
  } xlat_t;

endpackage

// file: tb/xmap_window_mapper_properties.sv
// checker for the window mapper, bound to its ports
// assumes the design package is compiled first
`timescale 1ns/100ps
module xmap_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // watched ports
  input wire xmap_pkg::core_req_t core_req,
  input wire logic [7:0] bank_rdata_q,
  input wire logic bank_hit_q,
  input wire xmap_pkg::xlat_t xlat_q,
  input var xmap_pkg::target_t target_q,
  input wire logic [7:0] flash_window_primary_bank_q,
  input wire logic [7:0] flash_window_secondary_bank_q,
  input wire logic [7:0] isa_io_window_bank_q,
  input wire logic [7:0] isa_memory_window_bank_q
);
  import xmap_pkg::*;
  logic cd, xd;
  logic [15:0] a;
  assign a = core_req.addr;
  assign cd = core_req.valid && core_req.kind == acc_code;
  assign xd = core_req.valid && core_req.kind == acc_xdata;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence prim_wr;
    xd && core_req.write && a == off_flash_primary;
  endsequence
  a_fixed_code: assert property (cd && a[15:14] == 2'b00 |=>
    xlat_q.flash_addr == {6'h00, $past(a[13:0])}) else $error("fixed code map");
  a_primary_code: assert property (cd && a[14] |=>
    xlat_q.flash_addr == {$past(flash_window_primary_bank_q[5:0]), $past(a[13:0])})
    else $error("primary window map");
  a_secondary_map: assert property ((cd || xd) && a[15:14] == 2'b10 |=>
    xlat_q.flash_addr[19:14] == $past(flash_window_secondary_bank_q[5:0]))
    else $error("secondary window map");
  a_isa_io_map: assert property (xd && a[15:8] == 8'h40 |=> target_q == tgt_isa_io &&
    xlat_q.isa_io_addr == {$past(isa_io_window_bank_q), $past(a[7:0])}) else $error("io map");
  a_isa_mem_map: assert property (xd && a[15:12] == 4'h5 |=> target_q == tgt_isa_mem)
    else $error("isa memory map");
  a_direct_special: assert property (core_req.valid && core_req.kind == acc_direct |=>
    target_q == ($past(a[7]) ? tgt_special_function_space : tgt_iram))
    else $error("direct decode");
  a_primary_write: assert property (prim_wr |=> bank_hit_q &&
    flash_window_primary_bank_q == $past(core_req.wdata)) else $error("bank write");
  a_low_onchip: assert property (xd && a[15:14] == 2'b00 |=> target_q == tgt_onchip)
    else $error("low xdata decode");
endmodule

bind xmap_window_mapper xmap_checker chk (.*);

// file: tb/xmap_core_model.sv
// core model: issues one request per cycle
// assumes the bench calls put only after reset is released
`timescale 1ns/100ps
module xmap_core_model (
  // clock
  input wire logic mclk,
  // request to the mapper
  output xmap_pkg::core_req_t req
);
  import xmap_pkg::*;
  initial req = '0;
  // driven at the falling edge so it is steady at the sampling edge
  task put(input logic w, input access_t k, input logic [15:0] ad, input logic [7:0] d);
    @(negedge mclk);
    req = {1'b1, w, k, ad, d};
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the window mapper
// assumes core model and checker are compiled before it
`timescale 1ns/100ps
module tb;
  import xmap_pkg::*;
  logic mclk, reset, hit;
  core_req_t req;
  xlat_t xl;
  target_t tg;
  logic [7:0] rd, pp, ps, pio, pm;
  logic [7:0] mb [4];
  logic [31:0] seed, r;
  int fail_count, cmp_count, cyc;
  logic [15:0] offs [4] = '{off_flash_secondary, off_flash_primary, off_isa_io, off_isa_mem};
  logic [15:0] edg [8] = '{16'h3fff, 16'h40ff, 16'h4100, 16'h4fff, 16'h5000, 16'h5fff,
    16'h6000, 16'h8000};
  xmap_core_model core (.mclk(mclk), .req(req));
  xmap_window_mapper dut (.mclk(mclk), .reset(reset), .core_req(req), .bank_rdata_q(rd),
    .bank_hit_q(hit), .xlat_q(xl), .target_q(tg), .flash_window_primary_bank_q(pp),
    .flash_window_secondary_bank_q(ps), .isa_io_window_bank_q(pio),
    .isa_memory_window_bank_q(pm));
  function automatic target_t etg(access_t k, logic [15:0] a);
    if (k == acc_direct) return a[7] ? tgt_special_function_space : tgt_iram;
    if (k != acc_xdata) return k == acc_code ? tgt_flash : tgt_iram;
    if (a[15]) return tgt_flash;
    if (a[15:14] == 2'b00) return tgt_onchip;
    if (a[15:8] == 8'h40) return tgt_isa_io;
    return a[15:12] == 4'h5 ? tgt_isa_mem : tgt_periph;
  endfunction
  function automatic logic [19:0] efl(logic [15:0] a);
    if (a[15:14] == 2'b00) return {6'h00, a[13:0]};
    return {(a[15:14] == 2'b10 ? mb[0][5:0] : mb[1][5:0]), a[13:0]};
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task go(input logic w, input access_t k, input logic [15:0] a, input logic [7:0] d);
    int j;
    j = -1;
    for (int m = 0; m < 4; m++) if (k == acc_xdata && a == offs[m]) j = m;
    core.put(w, k, a, d);
    @(posedge mclk);
    #1;
    chk("target", 32'(etg(k, a)), 32'(tg));
    chk("hit", 32'(j >= 0), 32'(hit));
    chk("rdata", (j >= 0 && !w) ? 32'(mb[j]) : 32'h0, 32'(rd));
    chk("io", 32'({mb[2], a[7:0]}), 32'(xl.isa_io_addr));
    chk("mem", 32'({mb[3], a[11:0]}), 32'(xl.isa_mem_addr));
    chk("bit", 32'(a[7:0] >= 8'h20 && a[7:0] <= 8'h2f), 32'(xl.bit_area));
    chk("iram", 32'(a[7:0]), 32'(xl.iram_addr));
    chk("pass", {6'h00, 1'b1, w && k != acc_code, a, d},
      {6'h00, xl.valid, xl.write, xl.local_addr, xl.wdata});
    if (etg(k, a) == tgt_flash) chk("flash", 32'(efl(a)), 32'(xl.flash_addr));
    if (j >= 0 && w) mb[j] = d;
    chk("banks", {mb[0], mb[1], mb[2], mb[3]}, {ps, pp, pio, pm});
  endtask
  task give_verdict;
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    seed = 32'he925ba12;
    reset = 1;
    mb = '{default: 8'h00};
    repeat (20) @(posedge mclk);
    @(negedge mclk) reset = 0;
    chk("reset", 32'h0, {ps, pp, pio, pm});
    for (int m = 0; m < 4; m++) begin
      go(1, acc_xdata, offs[m], 8'($random(seed)));
      go(0, acc_xdata, offs[m], 8'h00);
    end
    $display("test banks done");
    go(1, acc_xdata, off_isa_io, 8'h3c);
    go(0, acc_xdata, 16'h4012, 8'h00);
    go(1, acc_xdata, off_flash_primary, 8'hff);
    go(0, acc_code, 16'h7fff, 8'h00);
    go(1, acc_code, 16'hc000, 8'h00);
    go(0, acc_direct, 16'h0080, 8'h00);
    go(0, acc_indirect, 16'h00ff, 8'h00);
    for (int m = 0; m < 8; m++) go(0, acc_xdata, edg[m], 8'h00);
    $display("test corners done");
    repeat (300) begin
      r = $random(seed);
      go(r[0], access_t'(r[2:1]), r[3] ? offs[r[5:4]] : r[31:16], r[15:8]);
    end
    $display("test random done");
    give_verdict;
  end
endmodule
